//--- fsp_status_protect.sv
// Status register bank and write-protection logic of a serial flash.
`timescale 1ns/1ps
module fsp_status_protect (
  // Clock and resets
  input wire logic i_clock,
  input wire logic i_rst_b,
  input wire logic i_nv_blank_b,
  // Command port from the serial front end
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic [22:0] i_cmd_addr,
  input wire logic [7:0] i_cmd_data,
  input wire logic i_cmd_whole,
  // Protect pin
  input wire logic i_protect_pin_n,
  // Command answers
  output logic o_cmd_done,
  output logic o_cmd_reject,
  output logic [7:0] o_rd_data,
  output logic o_rd_valid,
  // Status and configuration
  output logic o_busy,
  output logic o_write_enable_latch,
  output logic o_erase_paused,
  output logic o_program_paused,
  output logic o_quad_enable,
  output logic [1:0] o_drive_strength,
  output logic o_dummy_select,
  output logic [2:0] o_otp_lock
);

  fsp_pkg::fsp_state_s st_reg;
  fsp_pkg::fsp_state_s st_next;
  fsp_prot_if prot ();

  logic pin_high;
  logic [7:0] sr1;
  logic [7:0] sr2;
  logic [7:0] sr3;
  logic idle;
  logic sr_unlocked;
  logic write_ok;
  logic [22:0] op_mask;
  logic [22:0] op_lo;
  logic [22:0] op_hi;
  logic op_protected;
  logic chip_ok;

  // ---------------------------------------------------------------
  // Protect pin and region decoder
  // ---------------------------------------------------------------
  fsp_pin_filter u_pin (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_pin(i_protect_pin_n),
    .o_level(pin_high)
  );

  assign prot.bp = st_reg.bp;
  assign prot.cmp = st_reg.cmp;

  fsp_region_decode u_decode (
    .prot(prot)
  );

  // ---------------------------------------------------------------
  // Status bytes as read back
  // ---------------------------------------------------------------
  always_comb begin
    sr1 = 8'h00;
    sr1[fsp_pkg::FSP_SR1_BUSY_BIT] = st_reg.busy;
    sr1[fsp_pkg::FSP_SR1_WEL_BIT] = st_reg.write_enable_latch;
    sr1[fsp_pkg::FSP_SR1_BP_LSB +: 5] = st_reg.bp;
    sr1[fsp_pkg::FSP_SR1_SEL0_BIT] = st_reg.sel0;
    sr2 = 8'h00;
    sr2[fsp_pkg::FSP_SR2_SEL1_BIT] = st_reg.sel1;
    sr2[fsp_pkg::FSP_SR2_QE_BIT] = st_reg.qe;
    sr2[fsp_pkg::FSP_SR2_PPAUSE_BIT] = st_reg.program_paused;
    sr2[fsp_pkg::FSP_SR2_OTP_LSB +: 3] = st_reg.otp;
    sr2[fsp_pkg::FSP_SR2_CMP_BIT] = st_reg.cmp;
    sr2[fsp_pkg::FSP_SR2_EPAUSE_BIT] = st_reg.erase_paused;
    sr3 = 8'h00;
    sr3[fsp_pkg::FSP_SR3_DC_BIT] = st_reg.dc;
    sr3[fsp_pkg::FSP_SR3_DRV_LSB +: 2] = st_reg.drv;
  end

  // ---------------------------------------------------------------
  // Gates for write-type commands
  // ---------------------------------------------------------------
  always_comb begin
    idle = !st_reg.busy && !st_reg.erase_paused && !st_reg.program_paused;
    write_ok = idle && st_reg.write_enable_latch && i_cmd_whole;
    unique case ({st_reg.sel1, st_reg.sel0})
      2'b00: sr_unlocked = 1'b1;
      2'b01: sr_unlocked = pin_high;
      2'b10: sr_unlocked = 1'b0;
      2'b11: sr_unlocked = 1'b0;
    endcase
    unique case (i_cmd_code)
      fsp_pkg::FSP_CMD_PROG: op_mask = fsp_pkg::FSP_PAGE_MASK;
      fsp_pkg::FSP_CMD_PROG_QUAD: op_mask = fsp_pkg::FSP_PAGE_MASK;
      fsp_pkg::FSP_CMD_WIPE_4K: op_mask = fsp_pkg::FSP_4K_MASK;
      fsp_pkg::FSP_CMD_ERASE_32K: op_mask = fsp_pkg::FSP_32K_MASK;
      default: op_mask = fsp_pkg::FSP_64K_MASK;
    endcase
    op_lo = i_cmd_addr & ~op_mask;
    op_hi = i_cmd_addr | op_mask;
    op_protected = prot.any && (op_lo <= prot.hi) && (op_hi >= prot.lo);
    chip_ok = ((st_reg.bp[2:0] == 3'h0) && !st_reg.cmp)
      || ((st_reg.bp[2:0] == 3'h7) && st_reg.cmp);
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rd_valid = 1'b0;
    st_next.done = 1'b0;
    st_next.reject = 1'b0;

    // Running operation counts down; the latch drops as it ends.
    if (st_reg.busy) begin
      if (st_reg.count == 12'h000) begin
        st_next.busy = 1'b0;
        st_next.write_enable_latch = 1'b0;
        st_next.op = fsp_pkg::FSP_OP_NONE;
      end else begin
        st_next.count = 12'(st_reg.count - 12'h001);
      end
    end

    if (i_cmd_valid) begin
      st_next.rst_armed = 1'b0;
      unique case (i_cmd_code)
        fsp_pkg::FSP_CMD_RD_SR1: begin
          st_next.rd_data = sr1;
          st_next.rd_valid = 1'b1;
          st_next.done = 1'b1;
        end
        fsp_pkg::FSP_CMD_RD_SR2: begin
          st_next.rd_data = sr2;
          st_next.rd_valid = 1'b1;
          st_next.done = 1'b1;
        end
        fsp_pkg::FSP_CMD_RD_SR3: begin
          st_next.rd_data = sr3;
          st_next.rd_valid = 1'b1;
          st_next.done = 1'b1;
        end
        fsp_pkg::FSP_CMD_WREN: begin
          if (idle && i_cmd_whole) begin
            st_next.write_enable_latch = 1'b1;
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_WRDI: begin
          if (idle && i_cmd_whole) begin
            st_next.write_enable_latch = 1'b0;
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_WR_SR1, fsp_pkg::FSP_CMD_WR_SR2, fsp_pkg::FSP_CMD_WR_SR3: begin
          if (write_ok && sr_unlocked) begin
            if (i_cmd_code == fsp_pkg::FSP_CMD_WR_SR1) begin
              st_next.bp = i_cmd_data[fsp_pkg::FSP_SR1_BP_LSB +: 5];
              st_next.sel0 = i_cmd_data[fsp_pkg::FSP_SR1_SEL0_BIT];
            end else if (i_cmd_code == fsp_pkg::FSP_CMD_WR_SR2) begin
              st_next.sel1 = i_cmd_data[fsp_pkg::FSP_SR2_SEL1_BIT];
              st_next.qe = i_cmd_data[fsp_pkg::FSP_SR2_QE_BIT];
              st_next.otp = st_reg.otp | i_cmd_data[fsp_pkg::FSP_SR2_OTP_LSB +: 3];
              st_next.cmp = i_cmd_data[fsp_pkg::FSP_SR2_CMP_BIT];
            end else begin
              st_next.dc = i_cmd_data[fsp_pkg::FSP_SR3_DC_BIT];
              st_next.drv = i_cmd_data[fsp_pkg::FSP_SR3_DRV_LSB +: 2];
            end
            st_next.busy = 1'b1;
            st_next.op = fsp_pkg::FSP_OP_SR;
            st_next.count = 12'(fsp_pkg::FSP_CYC_SR - 12'h001);
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_PROG, fsp_pkg::FSP_CMD_PROG_QUAD: begin
          if (write_ok && !op_protected) begin
            st_next.busy = 1'b1;
            st_next.op = fsp_pkg::FSP_OP_PROG;
            st_next.count = 12'(fsp_pkg::FSP_CYC_PROG - 12'h001);
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_WIPE_4K: begin
          if (write_ok && !op_protected) begin
            st_next.busy = 1'b1;
            st_next.op = fsp_pkg::FSP_OP_ERASE;
            st_next.count = 12'(fsp_pkg::FSP_CYC_WIPE - 12'h001);
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_ERASE_32K, fsp_pkg::FSP_CMD_ERASE_64K: begin
          if (write_ok && !op_protected) begin
            st_next.busy = 1'b1;
            st_next.op = fsp_pkg::FSP_OP_ERASE;
            st_next.count = 12'(fsp_pkg::FSP_CYC_BLOCK - 12'h001);
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_CHIP_A, fsp_pkg::FSP_CMD_CHIP_B: begin
          if (write_ok && chip_ok) begin
            st_next.busy = 1'b1;
            st_next.op = fsp_pkg::FSP_OP_ERASE;
            st_next.count = 12'(fsp_pkg::FSP_CYC_CHIP - 12'h001);
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_SUSPEND: begin
          // Suspend freezes the countdown; busy drops while paused.
          if (st_reg.busy && (st_reg.op == fsp_pkg::FSP_OP_ERASE) && (st_reg.count != 12'h000)) begin
            st_next.busy = 1'b0;
            st_next.erase_paused = 1'b1;
            st_next.done = 1'b1;
          end else if (st_reg.busy && (st_reg.op == fsp_pkg::FSP_OP_PROG) && (st_reg.count != 12'h000)) begin
            st_next.busy = 1'b0;
            st_next.program_paused = 1'b1;
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_RESUME: begin
          if (st_reg.erase_paused || st_reg.program_paused) begin
            st_next.busy = 1'b1;
            st_next.erase_paused = 1'b0;
            st_next.program_paused = 1'b0;
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        fsp_pkg::FSP_CMD_RST_EN: begin
          st_next.rst_armed = 1'b1;
          st_next.done = 1'b1;
        end
        fsp_pkg::FSP_CMD_RST: begin
          if (st_reg.rst_armed) begin
            st_next.write_enable_latch = 1'b0;
            st_next.busy = 1'b0;
            st_next.erase_paused = 1'b0;
            st_next.program_paused = 1'b0;
            st_next.op = fsp_pkg::FSP_OP_NONE;
            st_next.count = 12'h000;
            st_next.done = 1'b1;
          end else begin
            st_next.reject = 1'b1;
          end
        end
        default: begin
          st_next.rst_armed = 1'b0;
        end
      endcase
    end

    // Power-up: volatile state clears; nonvolatile state is kept, except that select 10 clears to 00 and a blank part loads the reset values.
    if (!i_rst_b) begin
      st_next.write_enable_latch = 1'b0;
      st_next.busy = 1'b0;
      st_next.erase_paused = 1'b0;
      st_next.program_paused = 1'b0;
      st_next.op = fsp_pkg::FSP_OP_NONE;
      st_next.count = 12'h000;
      st_next.rst_armed = 1'b0;
      st_next.rd_data = 8'h00;
      st_next.rd_valid = 1'b0;
      st_next.done = 1'b0;
      st_next.reject = 1'b0;
      if (st_reg.sel1 && !st_reg.sel0) begin
        st_next.sel1 = 1'b0;
        st_next.sel0 = 1'b0;
      end
      if (!i_nv_blank_b) begin
        st_next.bp = fsp_pkg::FSP_BP_RESET;
        st_next.sel0 = 1'b0;
        st_next.sel1 = 1'b0;
        st_next.cmp = 1'b0;
        st_next.otp = fsp_pkg::FSP_OTP_RESET;
        st_next.qe = 1'b0;
        st_next.drv = fsp_pkg::FSP_DRV_RESET;
        st_next.dc = 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    st_reg <= st_next;
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign o_cmd_done = st_reg.done;
  assign o_cmd_reject = st_reg.reject;
  assign o_rd_data = st_reg.rd_data;
  assign o_rd_valid = st_reg.rd_valid;
  assign o_busy = st_reg.busy;
  assign o_write_enable_latch = st_reg.write_enable_latch;
  assign o_erase_paused = st_reg.erase_paused;
  assign o_program_paused = st_reg.program_paused;
  assign o_quad_enable = st_reg.qe;
  assign o_drive_strength = st_reg.drv;
  assign o_dummy_select = st_reg.dc;
  assign o_otp_lock = st_reg.otp;

endmodule

//--- fsp_pkg.sv
// Package of constants and types for the flash status and write-protection block.
package fsp_pkg;

  // ---------------------------------------------------------------
  // Command codes
  // ---------------------------------------------------------------
  localparam logic [7:0] FSP_CMD_WREN = 8'h06;
  localparam logic [7:0] FSP_CMD_WRDI = 8'h04;
  localparam logic [7:0] FSP_CMD_RD_SR1 = 8'h05;
  localparam logic [7:0] FSP_CMD_RD_SR2 = 8'h35;
  localparam logic [7:0] FSP_CMD_RD_SR3 = 8'h15;
  localparam logic [7:0] FSP_CMD_WR_SR1 = 8'h01;
  localparam logic [7:0] FSP_CMD_WR_SR2 = 8'h31;
  localparam logic [7:0] FSP_CMD_WR_SR3 = 8'h11;
  localparam logic [7:0] FSP_CMD_PROG = 8'h02;
  localparam logic [7:0] FSP_CMD_PROG_QUAD = 8'h32;
  localparam logic [7:0] FSP_CMD_WIPE_4K = 8'h20;
  localparam logic [7:0] FSP_CMD_ERASE_32K = 8'h52;
  localparam logic [7:0] FSP_CMD_ERASE_64K = 8'hD8;
  localparam logic [7:0] FSP_CMD_CHIP_A = 8'h60;
  localparam logic [7:0] FSP_CMD_CHIP_B = 8'hC7;
  localparam logic [7:0] FSP_CMD_RST_EN = 8'h66;
  localparam logic [7:0] FSP_CMD_RST = 8'h99;
  localparam logic [7:0] FSP_CMD_SUSPEND = 8'h75;
  localparam logic [7:0] FSP_CMD_RESUME = 8'h7A;

  // ---------------------------------------------------------------
  // Status bit positions within each byte
  // ---------------------------------------------------------------
  localparam int FSP_SR1_BUSY_BIT = 0;
  localparam int FSP_SR1_WEL_BIT = 1;
  localparam int FSP_SR1_BP_LSB = 2;
  localparam int FSP_SR1_SEL0_BIT = 7;
  localparam int FSP_SR2_SEL1_BIT = 0;
  localparam int FSP_SR2_QE_BIT = 1;
  localparam int FSP_SR2_PPAUSE_BIT = 2;
  localparam int FSP_SR2_OTP_LSB = 3;
  localparam int FSP_SR2_CMP_BIT = 6;
  localparam int FSP_SR2_EPAUSE_BIT = 7;
  localparam int FSP_SR3_DC_BIT = 0;
  localparam int FSP_SR3_DRV_LSB = 5;

  // ---------------------------------------------------------------
  // Reset values of the nonvolatile fields
  // ---------------------------------------------------------------
  localparam logic [4:0] FSP_BP_RESET = 5'h00;
  localparam logic [1:0] FSP_DRV_RESET = 2'h1;
  localparam logic [2:0] FSP_OTP_RESET = 3'h0;

  // ---------------------------------------------------------------
  // Array geometry
  // ---------------------------------------------------------------
  localparam logic [22:0] FSP_ADDR_MAX = 23'h7FFFFF;
  localparam logic [22:0] FSP_SMALL_UNIT = 23'h001000;
  localparam logic [22:0] FSP_BIG_UNIT = 23'h020000;
  localparam logic [22:0] FSP_PAGE_MASK = 23'h0000FF;
  localparam logic [22:0] FSP_4K_MASK = 23'h000FFF;
  localparam logic [22:0] FSP_32K_MASK = 23'h007FFF;
  localparam logic [22:0] FSP_64K_MASK = 23'h00FFFF;

  // ---------------------------------------------------------------
  // Operation times
  // ---------------------------------------------------------------
  localparam int FSP_CLK_NS = 50;
  localparam int FSP_T_SR_NS = 50000;
  localparam int FSP_T_PROG_NS = 100000;
  localparam int FSP_T_WIPE_NS = 150000;
  localparam int FSP_T_BLOCK_NS = 180000;
  localparam int FSP_T_CHIP_NS = 200000;
  localparam logic [11:0] FSP_CYC_SR = 12'(FSP_T_SR_NS / FSP_CLK_NS);
  localparam logic [11:0] FSP_CYC_PROG = 12'(FSP_T_PROG_NS / FSP_CLK_NS);
  localparam logic [11:0] FSP_CYC_WIPE = 12'(FSP_T_WIPE_NS / FSP_CLK_NS);
  localparam logic [11:0] FSP_CYC_BLOCK = 12'(FSP_T_BLOCK_NS / FSP_CLK_NS);
  localparam logic [11:0] FSP_CYC_CHIP = 12'(FSP_T_CHIP_NS / FSP_CLK_NS);

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    FSP_OP_NONE = 2'b00,
    FSP_OP_SR = 2'b01,
    FSP_OP_PROG = 2'b10,
    FSP_OP_ERASE = 2'b11
  } fsp_op_e;

  typedef struct packed {
    logic [4:0] bp;
    logic sel0;
    logic sel1;
    logic cmp;
    logic [2:0] otp;
    logic qe;
    logic [1:0] drv;
    logic dc;
    logic write_enable_latch;
    logic busy;
    logic erase_paused;
    logic program_paused;
    fsp_op_e op;
    logic [11:0] count;
    logic rst_armed;
    logic [7:0] rd_data;
    logic rd_valid;
    logic done;
    logic reject;
  } fsp_state_s;

endpackage

//--- fsp_prot_if.sv
// Interface carrying the protect fields to the region decoder and the region back.
`timescale 1ns/1ps
interface fsp_prot_if;
  logic [4:0] bp;
  logic cmp;
  logic any;
  logic [22:0] lo;
  logic [22:0] hi;
  modport decoder (input bp, input cmp, output any, output lo, output hi);
  modport user (output bp, output cmp, input any, input lo, input hi);
endinterface

//--- fsp_region_decode.sv
// Decoder from the protect field and complement select to a protected address range.
`timescale 1ns/1ps
module fsp_region_decode (
  fsp_prot_if.decoder prot
);

  logic [2:0] low3;
  logic [2:0] shift;
  logic [22:0] size;
  logic none0;
  logic all0;
  logic [22:0] lo0;
  logic [22:0] hi0;

  // ---------------------------------------------------------------
  // Range with complement off, then complemented when selected
  // ---------------------------------------------------------------
  always_comb begin
    low3 = prot.bp[2:0];
    none0 = (low3 == 3'h0);
    all0 = (low3 == 3'h7);
    if (prot.bp[4]) begin
      shift = (low3 >= 3'h4) ? 3'h3 : 3'(low3 - 3'h1);
      size = fsp_pkg::FSP_SMALL_UNIT << shift;
    end else begin
      shift = 3'(low3 - 3'h1);
      size = fsp_pkg::FSP_BIG_UNIT << shift;
    end
    if (all0) begin
      lo0 = 23'h000000;
      hi0 = fsp_pkg::FSP_ADDR_MAX;
    end else if (prot.bp[3]) begin
      lo0 = 23'h000000;
      hi0 = 23'(size - 23'h000001);
    end else begin
      lo0 = ~23'(size - 23'h000001);
      hi0 = fsp_pkg::FSP_ADDR_MAX;
    end
    if (!prot.cmp) begin
      prot.any = !none0;
      prot.lo = lo0;
      prot.hi = hi0;
    end else if (none0) begin
      prot.any = 1'b1;
      prot.lo = 23'h000000;
      prot.hi = fsp_pkg::FSP_ADDR_MAX;
    end else if (all0) begin
      prot.any = 1'b0;
      prot.lo = 23'h000000;
      prot.hi = 23'h000000;
    end else if (lo0 == 23'h000000) begin
      prot.any = 1'b1;
      prot.lo = 23'(hi0 + 23'h000001);
      prot.hi = fsp_pkg::FSP_ADDR_MAX;
    end else begin
      prot.any = 1'b1;
      prot.lo = 23'h000000;
      prot.hi = 23'(lo0 - 23'h000001);
    end
  end

endmodule

//--- fsp_pin_filter.sv
// Three-stage synchroniser for the protect pin with an agreement filter.
`timescale 1ns/1ps
module fsp_pin_filter (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Pin and filtered level
  input wire logic i_pin,
  output logic o_level
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
  } fsp_pin_s;

  fsp_pin_s pin_reg;
  fsp_pin_s pin_next;

  // ---------------------------------------------------------------
  // The level follows only once the second and third stage agree
  // ---------------------------------------------------------------
  always_comb begin
    pin_next.s1 = i_pin;
    pin_next.s2 = pin_reg.s1;
    pin_next.s3 = pin_reg.s2;
    pin_next.level = (pin_reg.s2 == pin_reg.s3) ? pin_reg.s3 : pin_reg.level;
    if (!i_rst_b) begin
      pin_next = '1;
    end
  end

  always_ff @(posedge i_clock) begin
    pin_reg <= pin_next;
  end

  assign o_level = pin_reg.level;

endmodule

//--- fsp_status_protect_props.sv
// Port checker of the flash status and protection block.
`timescale 1ns/1ps
module fsp_status_protect_props (
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Command port
  input wire logic i_cmd_valid,
  input wire logic [7:0] i_cmd_code,
  input wire logic o_cmd_done,
  input wire logic o_cmd_reject,
  input wire logic [7:0] o_rd_data,
  input wire logic o_rd_valid,
  // Status
  input wire logic o_busy,
  input wire logic o_write_enable_latch
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  wire sr_wr = i_cmd_valid && i_cmd_code == fsp_pkg::FSP_CMD_WR_SR1;
  wire wr_op = i_cmd_valid && i_cmd_code inside {fsp_pkg::FSP_CMD_WR_SR1, fsp_pkg::FSP_CMD_PROG};
  wire rd_lo = i_cmd_valid && i_cmd_code == fsp_pkg::FSP_CMD_RD_SR1;
  wire rd_hi = i_cmd_valid && i_cmd_code == fsp_pkg::FSP_CMD_RD_SR3;
  wire susp = i_cmd_valid && i_cmd_code == fsp_pkg::FSP_CMD_SUSPEND;
  busy_start_a: assert property (sr_wr ##1 o_cmd_done |-> o_busy)
    else $error("busy not raised");
  busy_hold_a: assert property ($rose(o_busy) |-> o_busy [*8])
    else $error("busy dropped early");
  busy_refuse_a: assert property (wr_op && o_busy |=> o_cmd_reject)
    else $error("write taken while busy");
  latch_gate_a: assert property (wr_op && !o_write_enable_latch |=> o_cmd_reject && !o_cmd_done)
    else $error("write taken with latch clear");
  latch_clear_a: assert property ($fell(o_busy) && !$past(susp) |-> !o_write_enable_latch)
    else $error("latch left set");
  low_flags_a: assert property (rd_lo && !o_busy |=> o_rd_data[1:0] == {o_write_enable_latch, 1'b0})
    else $error("low byte flags wrong");
  read_answer_a: assert property (rd_lo || rd_hi |=> o_rd_valid && o_cmd_done && !o_cmd_reject)
    else $error("read not answered");
  reserved_zero_a: assert property (rd_hi |=> (o_rd_data & 8'h9E) == 8'h00)
    else $error("reserved bits set");
  cover property (sr_wr ##1 o_cmd_done);
  cover property (wr_op ##1 o_cmd_reject);
  cover property ($fell(o_busy));
endmodule

bind fsp_status_protect fsp_status_protect_props u_fsp_status_protect_props (.i_clock(i_clock), .i_rst_b(i_rst_b),
  .i_cmd_valid(i_cmd_valid), .i_cmd_code(i_cmd_code), .o_cmd_done(o_cmd_done), .o_cmd_reject(o_cmd_reject),
  .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid), .o_busy(o_busy), .o_write_enable_latch(o_write_enable_latch));

//--- fsp_host_model.sv
// Behavioural host that issues decoded commands and gathers the answers.
`timescale 1ns/1ps
module fsp_host_model (
  // Clock
  input wire logic i_clock,
  // Command request
  output logic o_cmd_valid,
  output logic [7:0] o_cmd_code,
  output logic [22:0] o_cmd_addr,
  output logic [7:0] o_cmd_data,
  output logic o_cmd_whole,
  // Answers
  input wire logic i_cmd_done,
  input wire logic i_cmd_reject,
  input wire logic [7:0] i_rd_data
);
  initial begin
    o_cmd_valid = 1'b0;
    o_cmd_code = 8'h00;
    o_cmd_addr = 23'h000000;
    o_cmd_data = 8'h00;
    o_cmd_whole = 1'b1;
  end
  // Code, address and data are inverted once released so a stale value is never mistaken for a command.
  task automatic send(input logic [7:0] c, input logic [22:0] a, input logic [7:0] d,
                      output logic [1:0] ans, output logic [7:0] rd);
    @(posedge i_clock);
    o_cmd_valid <= 1'b1;
    o_cmd_code <= c;
    o_cmd_addr <= a;
    o_cmd_data <= d;
    @(posedge i_clock);
    o_cmd_valid <= 1'b0;
    o_cmd_code <= ~c;
    o_cmd_addr <= ~a;
    o_cmd_data <= ~d;
    #1;
    ans = {i_cmd_done, i_cmd_reject};
    rd = i_rd_data;
  endtask
endmodule

//--- fsp_status_protect_tb.sv
// Self-checking testbench of the flash status and protection block.
`timescale 1ns/1ps
module fsp_status_protect_tb;
  localparam logic [7:0] WEN = fsp_pkg::FSP_CMD_WREN;
  localparam logic [7:0] WS1 = fsp_pkg::FSP_CMD_WR_SR1;
  localparam logic [7:0] WS2 = fsp_pkg::FSP_CMD_WR_SR2;
  localparam logic [7:0] WS3 = fsp_pkg::FSP_CMD_WR_SR3;
  localparam logic [7:0] RS1 = fsp_pkg::FSP_CMD_RD_SR1;
  localparam logic [7:0] RS2 = fsp_pkg::FSP_CMD_RD_SR2;
  localparam logic [7:0] RS3 = fsp_pkg::FSP_CMD_RD_SR3;
  localparam logic [7:0] PRG = fsp_pkg::FSP_CMD_PROG;
  localparam logic [1:0] OK = 2'b10;
  localparam logic [1:0] NO = 2'b01;
  logic i_clock;
  logic i_rst_b;
  logic blank_b;
  logic pin_n;
  logic valid;
  logic [7:0] code;
  logic [22:0] addr;
  logic [7:0] data;
  logic whole;
  logic done;
  logic reject;
  logic [7:0] rdat;
  logic busy;
  wire [9:0] cfg;
  int n_fail;
  int num_checks;
  fsp_host_model u_fsp_host_model (.i_clock(i_clock), .o_cmd_valid(valid), .o_cmd_code(code), .o_cmd_addr(addr),
    .o_cmd_data(data), .o_cmd_whole(whole), .i_cmd_done(done), .i_cmd_reject(reject), .i_rd_data(rdat));
  fsp_status_protect u_fsp_status_protect (.i_clock(i_clock), .i_rst_b(i_rst_b), .i_nv_blank_b(blank_b),
    .i_cmd_valid(valid), .i_cmd_code(code), .i_cmd_addr(addr), .i_cmd_data(data), .i_cmd_whole(whole),
    .i_protect_pin_n(pin_n), .o_cmd_done(done), .o_cmd_reject(reject), .o_rd_data(rdat), .o_rd_valid(),
    .o_busy(busy), .o_write_enable_latch(cfg[0]), .o_erase_paused(cfg[9]), .o_program_paused(cfg[8]),
    .o_quad_enable(cfg[4]), .o_drive_strength(cfg[3:2]), .o_dummy_select(cfg[1]), .o_otp_lock(cfg[7:5]));
  initial begin
    i_clock = 1'b0;
    forever #25 i_clock = ~i_clock;
  end
  // ----------
  // Tasks
  // ----------
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic check_cfg(input logic [9:0] exp);
    num_checks++;
    if (cfg !== exp) begin
      n_fail++;
      $display("Error at %0t: outputs %h, expected %h", $time, cfg, exp);
    end
  endtask
  task automatic cmd(input logic [7:0] c, input logic [1:0] exp, input logic [7:0] d = 8'h00,
                     input logic [22:0] a = 23'h000000);
    logic [1:0] ans;
    logic [7:0] b;
    u_fsp_host_model.send(c, a, d, ans, b);
    check({6'h00, ans}, {6'h00, exp});
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] exp);
    logic [1:0] ans;
    logic [7:0] b;
    u_fsp_host_model.send(c, 23'h000000, 8'h00, ans, b);
    check({6'h00, ans}, {6'h00, OK});
    check(b, exp);
  endtask
  task automatic idle;
    int k;
    k = 0;
    while (busy !== 1'b0 && k < 5000) begin
      @(posedge i_clock);
      #1;
      k++;
    end
    if (k == 5000) begin
      n_fail++;
      $display("Error at %0t: busy never cleared", $time);
      results();
    end
  endtask
  task automatic rst(input logic b);
    @(posedge i_clock);
    i_rst_b <= 1'b0;
    blank_b <= b;
    repeat (8) @(posedge i_clock);
    i_rst_b <= 1'b1;
    blank_b <= 1'b1;
  endtask
  task automatic pin(input logic v);
    @(posedge i_clock);
    pin_n <= v;
    repeat (5) @(posedge i_clock);
  endtask
  task automatic results;
    $display("checks %0d, mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------
  // Sequence
  // ----------
  initial begin
    n_fail = 0;
    num_checks = 0;
    i_rst_b = 1'b0;
    blank_b = 1'b0;
    pin_n = 1'b1;
    rst(1'b0);
    rd(RS1, 8'h00);
    rd(RS2, 8'h00);
    rd(RS3, 8'h20);
    cmd(WS1, NO, 8'h04);
    cmd(WEN, OK);
    rd(RS1, 8'h02);
    cmd(WS1, OK, 8'h07);
    rd(RS1, 8'h07);
    cmd(WS1, NO, 8'h00);
    idle();
    rd(RS1, 8'h04);
    $display("test reset and writes ended");
    cmd(WEN, OK);
    cmd(PRG, NO, 8'h00, 23'h7E0000);
    cmd(PRG, OK, 8'h00, 23'h7DFF00);
    idle();
    cmd(WEN, OK);
    cmd(fsp_pkg::FSP_CMD_CHIP_A, NO);
    rd(RS1, 8'h06);
    cmd(WS2, OK, 8'h40);
    idle();
    cmd(WEN, OK);
    cmd(fsp_pkg::FSP_CMD_WIPE_4K, NO, 8'h00, 23'h000000);
    cmd(fsp_pkg::FSP_CMD_ERASE_64K, OK, 8'h00, 23'h7F0000);
    idle();
    cmd(WEN, OK);
    cmd(WS1, OK, 8'h1C);
    idle();
    cmd(WEN, OK);
    cmd(fsp_pkg::FSP_CMD_CHIP_B, OK);
    idle();
    cmd(WEN, OK);
    cmd(WS1, OK, 8'h50);
    idle();
    cmd(WEN, OK);
    cmd(PRG, NO, 8'h00, 23'h7F7F00);
    cmd(PRG, OK, 8'h00, 23'h7F8000);
    idle();
    $display("test protected range ended");
    cmd(WEN, OK);
    cmd(WS1, OK, 8'h9C);
    idle();
    pin(1'b0);
    cmd(WEN, OK);
    cmd(WS1, NO, 8'h00);
    rd(RS1, 8'h9E);
    pin(1'b1);
    cmd(WS1, OK, 8'h1C);
    idle();
    cmd(WEN, OK);
    cmd(WS2, OK, 8'h41);
    idle();
    cmd(WEN, OK);
    cmd(WS3, NO, 8'h00);
    rst(1'b1);
    rd(RS2, 8'h40);
    $display("test lock schemes ended");
    cmd(WEN, OK);
    cmd(WS3, OK, 8'hFF);
    idle();
    rd(RS3, 8'h61);
    cmd(WEN, OK);
    cmd(WS2, OK, 8'h48);
    idle();
    cmd(WEN, OK);
    cmd(WS2, OK, 8'h42);
    idle();
    rd(RS2, 8'h4A);
    check_cfg(10'h03E);
    cmd(WEN, OK);
    cmd(WS1, OK, 8'h9C);
    idle();
    cmd(WEN, OK);
    cmd(WS2, OK, 8'h49);
    idle();
    rst(1'b1);
    cmd(WEN, OK);
    cmd(WS1, NO, 8'h00);
    rd(RS2, 8'h49);
    cmd(fsp_pkg::FSP_CMD_WIPE_4K, OK, 8'h00, 23'h000000);
    cmd(fsp_pkg::FSP_CMD_SUSPEND, OK);
    rd(RS2, 8'hC9);
    check_cfg(10'h22F);
    cmd(fsp_pkg::FSP_CMD_RESUME, OK);
    idle();
    cmd(WEN, OK);
    cmd(fsp_pkg::FSP_CMD_RST_EN, OK);
    cmd(fsp_pkg::FSP_CMD_RST, OK);
    rd(RS1, 8'h9C);
    cmd(WEN, OK);
    cmd(fsp_pkg::FSP_CMD_WRDI, OK);
    rd(RS1, 8'h9C);
    $display("test lock bits ended");
    results();
  end
endmodule
